// *** verilog/lvi_consts.svh ***
`ifndef LVI_CONSTS_SVH
`define LVI_CONSTS_SVH

// ----------------------------------------
// timing of the send-frame guard interval
// ----------------------------------------
`define LVI_CLK_PERIOD_NS 100
`define LVI_GUARD_NS 125
// least time: round up to whole clock cycles
`define LVI_GUARD_CYC ((`LVI_GUARD_NS + `LVI_CLK_PERIOD_NS - 1) / `LVI_CLK_PERIOD_NS)

// ----------------------------------------
// synchroniser lanes and reset values
// ----------------------------------------
`define LVI_SY_RXA 0
`define LVI_SY_RXB 1
`define LVI_SY_FCL 2
`define LVI_SY_HIZ 3
// active-low test inputs idle high, line inputs idle low
`define LVI_SY_RESET 4'hC

`endif

// *** verilog/lvi_pkg.sv ***
`include "lvi_consts.svh"

package lvi_pkg;

  // ----------------------------------------
  // state of the frame delay line
  // ----------------------------------------
  typedef struct packed {
    logic [`LVI_GUARD_CYC-1:0] frame;
    logic [`LVI_GUARD_CYC-1:0] bits;
  } lvi_dly_state_t;

  // ----------------------------------------
  // state of the line interface top
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [1:0] trail;
    logic tx_out;
    logic tx_oe;
    logic sf;
    logic sf_oe;
    logic rx_a;
    logic rx_b;
  } lvi_state_t;

endpackage

// *** verilog/lvi_delay.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lvi_consts.svh"

// delays the frame flag and data bit by the guard interval
module lvi_delay
  import lvi_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // stream in
  input wire logic frame_in,
  input wire logic bit_in,
  // stream out, registered
  output logic frame_out,
  output logic bit_out
);

  lvi_dly_state_t q;
  lvi_dly_state_t next_q;

  // ----------------------------------------
  // shift stages
  // ----------------------------------------
  // a plain shift chain; the depth is tiny so no memory is needed
  always_comb begin
    next_q = q;
    next_q.frame = {q.frame[`LVI_GUARD_CYC-2:0], frame_in};
    next_q.bits = {q.bits[`LVI_GUARD_CYC-2:0], bit_in};
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign frame_out = q.frame[`LVI_GUARD_CYC-1];
  assign bit_out = q.bits[`LVI_GUARD_CYC-1];

endmodule // lvi_delay

`default_nettype wire

// *** verilog/lvi_line_if.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lvi_consts.svh"

module lvi_line_if
  import lvi_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // from the frame encoder, same clock
  input wire logic tx_frame,
  input wire logic tx_bit,
  // receive pins from physical layer
  input wire logic line_rx_channel_a,
  input wire logic line_rx_channel_b,
  // test and calibration pins
  input wire logic force_constant_light_n,
  input wire logic test_hiz_n,
  // transmit pins
  output logic line_tx_out,
  output logic line_tx_oe,
  output logic send_frame_enable,
  output logic send_frame_oe,
  // synchronised receive data to the decoder
  output logic rx_data_a,
  output logic rx_data_b
);

  localparam logic [1:0] GUARD = 2'(`LVI_GUARD_CYC);

  lvi_state_t q;
  lvi_state_t next_q;
  logic frame_d;
  logic bit_d;
  logic force_on;
  logic hiz_on;

  // ----------------------------------------
  // data delay: holds data back by the guard so sf can lead it
  // ----------------------------------------
  lvi_delay u_delay (
    .mclk(mclk),
    .rstn(rstn),
    .frame_in(tx_frame),
    .bit_in(tx_bit),
    .frame_out(frame_d),
    .bit_out(bit_d)
  );

  // only the second synchroniser stage is looked at
  assign force_on = !q.sync2[`LVI_SY_FCL];
  assign hiz_on = !q.sync2[`LVI_SY_HIZ];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_q = q;
    next_q.sync1 = {test_hiz_n, force_constant_light_n, line_rx_channel_b, line_rx_channel_a};
    next_q.sync2 = q.sync1;
    // trail counter reloads while delayed data runs, then counts out the guard
    if (frame_d) begin
      next_q.trail = GUARD;
    end else if (q.trail != 2'h0) begin
      next_q.trail = q.trail - 2'h1;
    end
    // sf rises with the raw frame, ahead of the delayed data
    next_q.sf = tx_frame | frame_d | (q.trail != 2'h0);
    // forced light wins over frame data; idle line is low
    next_q.tx_out = force_on | (frame_d & bit_d);
    next_q.tx_oe = !hiz_on;
    next_q.sf_oe = !hiz_on;
    next_q.rx_a = q.sync2[`LVI_SY_RXA];
    next_q.rx_b = q.sync2[`LVI_SY_RXB];
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.sync1 <= `LVI_SY_RESET;
      q.sync2 <= `LVI_SY_RESET;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from flops
  assign line_tx_out = q.tx_out;
  assign line_tx_oe = q.tx_oe;
  assign send_frame_enable = q.sf;
  assign send_frame_oe = q.sf_oe;
  assign rx_data_a = q.rx_a;
  assign rx_data_b = q.rx_b;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence frame_start_s;
    !tx_frame ##1 tx_frame;
  endsequence

  sequence delayed_end_s;
    frame_d ##1 !frame_d;
  endsequence

  sf_lead_a: assert property (frame_start_s |=> send_frame_enable [*2])
    else $error("send frame did not lead the frame");
  sf_trail_a: assert property (delayed_end_s |=> send_frame_enable [*2])
    else $error("send frame did not trail the frame");
  sf_covers_a: assert property ($past(frame_d) |-> send_frame_enable)
    else $error("data sent without send frame");
  data_delay_a: assert property ($past(tx_frame, 3) && $past(tx_bit, 3) |-> line_tx_out)
    else $error("frame bit lost on line output");
  force_light_a: assert property (force_on |=> line_tx_out)
    else $error("forced light did not hold output high");
  hiz_off_a: assert property (hiz_on |=> !line_tx_oe && !send_frame_oe)
    else $error("output driven in high impedance mode");
  hiz_drive_a: assert property (!hiz_on |=> line_tx_oe && send_frame_oe)
    else $error("output not driven in normal mode");
  idle_low_a: assert property (!tx_frame && !frame_d && q.trail == 2'h0 && !force_on
                               |=> !send_frame_enable && !line_tx_out)
    else $error("line not low while idle");
  rx_path_a: assert property (rx_data_a == $past(line_rx_channel_a, 3))
    else $error("receive channel a corrupted");
  // channel b has its own lane; a swapped lane would pass the channel a check alone
  rx_path_b_a: assert property (rx_data_b == $past(line_rx_channel_b, 3))
    else $error("receive channel b corrupted");

endmodule // lvi_line_if

`default_nettype wire

// *** test/lvi_phy_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------
// line transceivers, copper or fiber
// ----------------------------------
module lvi_phy_model (
  // from the device
  input wire logic tx_out,
  input wire logic tx_oe,
  input wire logic sf,
  input wire logic sf_oe,
  // fault command from the bench
  input wire logic b_dead,
  // to the device
  output logic rx_a,
  output logic rx_b
);
  logic bus;
  // drivers open only under send-frame, so a gated line idles low
  assign bus = sf && sf_oe && tx_oe && tx_out;
  assign rx_a = bus;
  // a dead receiver sits low whatever the line does
  assign rx_b = bus && !b_dead;
endmodule // lvi_phy_model
`default_nettype wire

// *** test/tb_lvi_line_if.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_lvi_line_if;
  logic mclk = 0, rstn = 0, tx_frame = 0, tx_bit = 0, fcl_n = 1, hiz_n = 1, b_dead = 0;
  logic out, out_oe, sf, sf_oe, rxa, rxb, da, db;
  int miscompares = 0, num_checks = 0, cyc = 0;
  // --------
  // harness
  // --------
  always #50 mclk = ~mclk;
  lvi_line_if dut (.mclk(mclk), .rstn(rstn), .tx_frame(tx_frame), .tx_bit(tx_bit),
    .line_rx_channel_a(rxa), .line_rx_channel_b(rxb), .force_constant_light_n(fcl_n),
    .test_hiz_n(hiz_n), .line_tx_out(out), .line_tx_oe(out_oe), .send_frame_enable(sf),
    .send_frame_oe(sf_oe), .rx_data_a(da), .rx_data_b(db));
  lvi_phy_model phy (.tx_out(out), .tx_oe(out_oe), .sf(sf), .sf_oe(sf_oe), .b_dead(b_dead),
    .rx_a(rxa), .rx_b(rxb));
  task chk(input string n, input logic e, input logic s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s exp %b got %b", n, e, s);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a hang counts as a mismatch; the whole run needs under 60 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc > 500) begin
      miscompares++;
      final_report;
    end
  end
  // ---------
  // scenarios
  // ---------
  // three-bit frame, looped back by the line; a zero bit in the middle
  task frame(input logic dead);
    logic [2:0] b;
    int i;
    b = 3'b101;
    for (i = 0; i < 9; i++) begin
      @(posedge mclk);
      tx_frame <= (i < 3);
      tx_bit <= (i < 3) ? b[i] : 1'b0;
      b_dead <= dead;
      @(negedge mclk);
      chk("sf", i >= 1 && i <= 7, sf);
      chk("out", (i >= 3 && i <= 5) ? b[i-3] : 1'b0, out);
      chk("rx_a", (i >= 6) ? b[i-6] : 1'b0, da);
      chk("rx_b", (i >= 6 && !dead) ? b[i-6] : 1'b0, db);
    end
    $display("test frame done");
  endtask
  task force_light;
    int i;
    for (i = 0; i < 8; i++) begin
      @(posedge mclk);
      fcl_n <= !(i < 3);
      @(negedge mclk);
      chk("out", i >= 3 && i <= 5, out);
      chk("sf", 1'b0, sf);
    end
    $display("test force_light done");
  endtask
  task hiz;
    int i;
    for (i = 0; i < 8; i++) begin
      @(posedge mclk);
      hiz_n <= !(i < 3);
      @(negedge mclk);
      chk("out_oe", !(i >= 3 && i <= 5), out_oe);
      chk("sf_oe", !(i >= 3 && i <= 5), sf_oe);
    end
    $display("test hiz done");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    chk("out", 1'b0, out);
    chk("sf", 1'b0, sf);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    frame(1'b0);
    frame(1'b1);
    force_light;
    hiz;
    final_report;
  end
endmodule // tb_lvi_line_if
`default_nettype wire
